//--- ucpm_port_logic.sv
// Charging-port mode and data-line sequencing logic with Wishbone registers
//
// What this block does
// - Dedicated charging has one auto-detect state choosing among three schemes.
// - Shorted scheme ties data lines together through at most 200 ohms.
// - Divider scheme drives 2.7 V onto both data lines.
// - Low-pull scheme shorts and pulls to 1.2 V, then goes shorted.
// - Auto-detect starts in the divider scheme.
// - Compliant attach: power stays on, no discharge, low-pull then shorted.
// - Shorted scheme holds until data line released, then back to divider.
// - Divider-compatible device keeps the machine in the divider state.
// - Client mode: power switch off, data switch on.
// - Data switches close in CDP, SDP or client mode, given enable.
// - Data switches enabled only while enable is high.
// - In CDP the data switches stay closed through the handshake.
// - Data switches open when enable low or in dedicated charging.
// - Current limit alone never opens the data switches.
// - Data switches open throughout port power discharge.
// - Mode decode: 00x DCP, 01x SDP, 10x client, 110 SDP, 111 CDP.
// - Changes 000<->001 or 110<->111 do not trigger discharge.
// - Codes 000 and 110 never assert the fault output on overcurrent.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ucpm_defines.svh"

module ucpm_port_logic
  import ucpm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES  = `UCPM_HOLD_CYCLES,
  parameter int unsigned DISCH_CYCLES = `UCPM_DISCH_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic [31:0]                dat_o,
  output logic                       ack_o,
  // Analog-side comparators and flags (asynchronous)
  input  wire logic                  attach_cmp_i,
  input  wire logic                  release_cmp_i,
  input  wire logic                  overcurrent_i,
  input  wire logic                  current_limit_i,
  // Analog controls
  output ucpm_pkg::ucpm_scheme_t     scheme_o,
  output logic                       short_lines_o,
  output logic                       drive_2v7_o,
  output logic                       pull_1v2_o,
  output logic                       power_switch_o,
  output logic                       data_switch_o,
  output logic                       discharge_o,
  output logic                       fault_n_o
);

  import ucpm_pkg::*;

  localparam int unsigned TW = 20;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]      mode_sel;
    logic            enable;
    logic [TW-1:0]   hold_len;
    ucpm_scheme_t    scheme;
    ucpm_mode_t      mode_d;
    logic [2:0]      mode_sel_d;
    logic            enable_d;
    logic            discharging;
    logic            oc_s1;
    logic            oc_s2;
    logic            cl_s1;
    logic            cl_s2;
    logic            ack;
    logic [31:0]     rdata;
    logic            short_lines;
    logic            drive_2v7;
    logic            pull_1v2;
    logic            power_sw;
    logic            data_sw;
    logic            fault_n;
  } ucpm_top_t;

  ucpm_top_t st;
  ucpm_top_t next_st;

  logic       attach_lvl;
  logic       release_lvl;
  logic       tmr_start;
  logic       tmr_busy;
  logic       tmr_done;
  logic       dis_start;
  logic       dis_busy;
  logic       dis_done;
  ucpm_mode_t mode;
  logic       req;
  logic       wr;

  // ---------------------------------------------------------------
  // Comparator conditioning
  // ---------------------------------------------------------------
  // attach filter
  ucpm_debounce u_attach (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (attach_cmp_i),
    .level_o (attach_lvl)
  );

  ucpm_debounce u_release (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (release_cmp_i),
    .level_o (release_lvl)
  );

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  // low-pull phase timer
  ucpm_timer #(.WIDTH(TW)) u_hold (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .load_i  (st.hold_len),
    .busy_o  (tmr_busy),
    .done_o  (tmr_done)
  );

  ucpm_timer #(.WIDTH(TW)) u_disch (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (dis_start),
    .load_i  (TW'(DISCH_CYCLES)),
    .busy_o  (dis_busy),
    .done_o  (dis_done)
  );

  // ---------------------------------------------------------------
  // Mode decode and sequencing
  // ---------------------------------------------------------------
  // mode decode
  always_comb begin
    case (st.mode_sel[2:1])
      2'b00:   mode = UCPM_MODE_DCP;
      2'b01:   mode = UCPM_MODE_SDP;
      2'b10:   mode = UCPM_MODE_CLIENT;
      default: mode = st.mode_sel[0] ? UCPM_MODE_CDP : UCPM_MODE_SDP;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // A request seen while ack is high is the tail of the last one
  assign req = cyc_i && stb_i && !st.ack;
  assign wr  = req && we_i;

  always_comb begin
    next_st   = st;
    tmr_start = 1'b0;
    dis_start = 1'b0;

    // -------------------------------------------------------------
    // Synchronisers and history
    // -------------------------------------------------------------
    next_st.oc_s1      = overcurrent_i;
    next_st.oc_s2      = st.oc_s1;
    next_st.cl_s1      = current_limit_i;
    next_st.cl_s2      = st.cl_s1;
    next_st.mode_d     = mode;
    next_st.mode_sel_d = st.mode_sel;
    next_st.enable_d   = st.enable;

    // -------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------
    // Bus slave: one wait state, ack for one cycle
    next_st.ack = req;
    if (wr && adr_i == `UCPM_ADDR_CTRL && sel_i[0]) begin
      next_st.mode_sel = dat_i[`UCPM_CTRL_MODE_LSB +: 3];
      next_st.enable   = dat_i[`UCPM_CTRL_EN_BIT];
    end
    // A new hold length applies from the next low-pull entry
    if (wr && adr_i == `UCPM_ADDR_HOLD) begin
      if (sel_i[0]) next_st.hold_len[7:0]   = dat_i[7:0];
      if (sel_i[1]) next_st.hold_len[15:8]  = dat_i[15:8];
      if (sel_i[2]) next_st.hold_len[19:16] = dat_i[19:16];
    end

    // -------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------
    // Attach and release read back filtered, as the machine sees them
    next_st.rdata = 32'h0000_0000;
    if (req && !we_i) begin
      case (adr_i)
        `UCPM_ADDR_CTRL: begin
          next_st.rdata[`UCPM_CTRL_MODE_LSB +: 3] = st.mode_sel;
          next_st.rdata[`UCPM_CTRL_EN_BIT]        = st.enable;
        end
        `UCPM_ADDR_STATUS: begin
          next_st.rdata[`UCPM_ST_SCHEME_LSB +: 2] = st.scheme;
          next_st.rdata[`UCPM_ST_DATA_SW_BIT]     = st.data_sw;
          next_st.rdata[`UCPM_ST_PWR_SW_BIT]      = st.power_sw;
          next_st.rdata[`UCPM_ST_DISCH_BIT]       = st.discharging;
          next_st.rdata[`UCPM_ST_FAULT_BIT]       = !st.fault_n;
          next_st.rdata[`UCPM_ST_ATTACH_BIT]      = attach_lvl;
          next_st.rdata[`UCPM_ST_RELEASE_BIT]     = release_lvl;
        end
        `UCPM_ADDR_HOLD: begin
          next_st.rdata[TW-1:0] = st.hold_len;
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // -------------------------------------------------------------
    // Output discharge
    // -------------------------------------------------------------
    // A restart mid-discharge reloads the full period
    // Discharge on a mode change or enable fall; pairs sharing a mode
    // family only shift the current limit, so the port stays powered.
    // discharge exemptions
    if ((st.mode_sel_d != st.mode_sel
         && st.mode_sel_d[2:1] != st.mode_sel[2:1])
        || (st.enable_d && !st.enable)) begin
      dis_start           = 1'b1;
      next_st.discharging = 1'b1;
    end else if (dis_done) begin
      next_st.discharging = 1'b0;
    end

    // -------------------------------------------------------------
    // Auto-detect machine
    // -------------------------------------------------------------
    // auto-detect machine runs only in dedicated charging
    if (mode != UCPM_MODE_DCP || !st.enable) begin
      // start in the divider scheme on every re-entry
      next_st.scheme = UCPM_SCH_DIVIDER;
    end else begin
      case (st.scheme)
        UCPM_SCH_DIVIDER: begin
          if (attach_lvl) begin
            next_st.scheme = UCPM_SCH_LOW_PULL;
            tmr_start      = 1'b1;
          end
        end
        UCPM_SCH_LOW_PULL: begin
          if (tmr_done) begin
            next_st.scheme = UCPM_SCH_SHORTED;
          end
        end
        UCPM_SCH_SHORTED: begin
          if (release_lvl) begin
            next_st.scheme = UCPM_SCH_DIVIDER;
          end
        end
        default: next_st.scheme = UCPM_SCH_DIVIDER;
      endcase
    end

    // -------------------------------------------------------------
    // Line controls
    // -------------------------------------------------------------
    // Analog line controls follow the scheme
    next_st.short_lines = 1'b0;
    next_st.drive_2v7   = 1'b0;
    next_st.pull_1v2    = 1'b0;
    if (mode == UCPM_MODE_DCP && st.enable) begin
      case (next_st.scheme)
        UCPM_SCH_DIVIDER: next_st.drive_2v7 = 1'b1;
        // short and pull to 1.2 V
        UCPM_SCH_LOW_PULL: begin
          next_st.short_lines = 1'b1;
          next_st.pull_1v2    = 1'b1;
        end
        UCPM_SCH_SHORTED: next_st.short_lines = 1'b1;
        default: next_st.short_lines = 1'b0;
      endcase
    end

    // -------------------------------------------------------------
    // Power and data switches
    // -------------------------------------------------------------
    // power stays on across the attach, no discharge issued
    next_st.power_sw = st.enable && mode != UCPM_MODE_CLIENT
                       && !next_st.discharging;

    // Current limit is deliberately not a term here.
    // data switch enable
    next_st.data_sw = st.enable && mode != UCPM_MODE_DCP
                      && !next_st.discharging;

    // -------------------------------------------------------------
    // Fault report
    // -------------------------------------------------------------
    // silent overcurrent for codes 000 and 110
    next_st.fault_n = !(st.oc_s2 && mode != UCPM_MODE_CLIENT
                        && st.mode_sel != 3'b000
                        && st.mode_sel != 3'b110);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st          <= '0;
      st.hold_len <= TW'(HOLD_CYCLES);
      st.fault_n  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dat_o          = st.rdata;
  assign ack_o          = st.ack;
  assign scheme_o       = st.scheme;
  assign short_lines_o  = st.short_lines;
  assign drive_2v7_o    = st.drive_2v7;
  assign pull_1v2_o     = st.pull_1v2;
  assign power_switch_o = st.power_sw;
  assign data_switch_o  = st.data_sw;
  assign discharge_o    = st.discharging;
  assign fault_n_o      = st.fault_n;

endmodule

//--- ucpm_defines.svh
// Offsets, field positions, reset values and timing counts of the port logic
`ifndef UCPM_DEFINES_SVH
`define UCPM_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define UCPM_ADDR_CTRL      4'h0
`define UCPM_ADDR_STATUS    4'h4
`define UCPM_ADDR_HOLD      4'h8

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define UCPM_CTRL_MODE_LSB  0
`define UCPM_CTRL_EN_BIT    3
`define UCPM_CTRL_RESET     32'h0000_0000

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define UCPM_ST_SCHEME_LSB  0
`define UCPM_ST_DATA_SW_BIT 2
`define UCPM_ST_PWR_SW_BIT  3
`define UCPM_ST_DISCH_BIT   4
`define UCPM_ST_FAULT_BIT   5
`define UCPM_ST_ATTACH_BIT  6
`define UCPM_ST_RELEASE_BIT 7

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define UCPM_CLK_MHZ        100
`define UCPM_HOLD_US        1000
`define UCPM_HOLD_CYCLES    (`UCPM_HOLD_US * `UCPM_CLK_MHZ)
`define UCPM_DEB_CYCLES     16
`define UCPM_DISCH_US       10
`define UCPM_DISCH_CYCLES   (`UCPM_DISCH_US * `UCPM_CLK_MHZ)

`endif

//--- ucpm_pkg.sv
// Types shared by the charging-port mode logic
package ucpm_pkg;

  typedef enum logic [1:0] {
    UCPM_SCH_DIVIDER,
    UCPM_SCH_LOW_PULL,
    UCPM_SCH_SHORTED,
    UCPM_SCH_NONE
  } ucpm_scheme_t;

  typedef enum logic [1:0] {
    UCPM_MODE_DCP,
    UCPM_MODE_SDP,
    UCPM_MODE_CLIENT,
    UCPM_MODE_CDP
  } ucpm_mode_t;

endpackage

//--- ucpm_debounce.sv
// Two-flop synchroniser followed by a stable-count debouncer
`timescale 1ns/10ps
`include "ucpm_defines.svh"

module ucpm_debounce (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      level_o
);

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [4:0]  cnt;
    logic        level;
  } ucpm_deb_t;

  ucpm_deb_t st;
  ucpm_deb_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = raw_i;
    next_st.sync2 = st.sync1;
    // Only the second flop feeds the filter
    if (st.sync2 == st.level) begin
      next_st.cnt = 5'h00;
    end else if (st.cnt == 5'(`UCPM_DEB_CYCLES - 1)) begin
      next_st.cnt   = 5'h00;
      next_st.level = st.sync2;
    end else begin
      next_st.cnt = st.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;

endmodule

//--- ucpm_timer.sv
// Down-counter that reports a single expiry pulse
`timescale 1ns/10ps

module ucpm_timer #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic [WIDTH-1:0] load_i,
  output logic                  busy_o,
  output logic                  done_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             busy;
  } ucpm_tmr_t;

  ucpm_tmr_t st;
  ucpm_tmr_t next_st;

  always_comb begin
    next_st      = st;
    if (start_i) begin
      next_st.cnt  = load_i;
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      if (st.cnt <= WIDTH'(1)) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.cnt = st.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_o = st.busy;
  // Done marks the last counted cycle, so a load of N spans exactly N cycles
  assign done_o = st.busy && st.cnt <= WIDTH'(1);

endmodule

//--- ucpm_port_logic_properties.sv
// Checker of the charging-port mode logic, with its bind
`timescale 1ns/10ps

module ucpm_port_logic_checker
  import ucpm_pkg::*;
(
  input logic                   clk_i,
  input logic                   rst_i,
  input logic                   cyc_i,
  input logic                   stb_i,
  input logic                   we_i,
  input logic [3:0]             adr_i,
  input logic [3:0]             sel_i,
  input logic [31:0]            dat_i,
  input logic                   ack_o,
  input ucpm_pkg::ucpm_scheme_t scheme_o,
  input logic                   short_lines_o,
  input logic                   drive_2v7_o,
  input logic                   pull_1v2_o,
  input logic                   data_switch_o,
  input logic                   discharge_o
);
  // ----------------
  // Control shadow
  // ----------------
  typedef struct packed {
    logic       en;
    logic [2:0] code;
    logic [1:0] dok;
    logic [3:0] chg;
    logic [2:0] ds;
  } ucpm_chk_t;
  ucpm_chk_t st;
  ucpm_chk_t next_st;
  logic      wr;
  logic      dok_now;
  logic      chg_now;

  // Shadow taken at the acked write; outputs lag it, so history is kept
  assign wr = cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0 && sel_i[0];
  assign dok_now = st.en && st.code[2:1] != 2'h0;
  assign chg_now = wr && (dat_i[2:1] != st.code[2:1] || (st.en && !dat_i[3]));

  always_comb begin
    next_st     = st;
    next_st.dok = {st.dok[0], dok_now};
    next_st.chg = {st.chg[2:0], chg_now};
    next_st.ds  = {st.ds[1:0], discharge_o};
    if (wr) begin
      next_st.en   = dat_i[3];
      next_st.code = dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------
  // Properties
  // ----------------
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_div; drive_2v7_o |-> scheme_o == UCPM_SCH_DIVIDER; endproperty
  a_div: assert property (p_div) else $error("drive outside divider");
  property p_lowp;
    scheme_o == UCPM_SCH_LOW_PULL |-> short_lines_o && pull_1v2_o;
  endproperty
  a_lowp: assert property (p_lowp) else $error("low-pull outputs");
  property p_shrt;
    scheme_o == UCPM_SCH_SHORTED |-> short_lines_o && !pull_1v2_o;
  endproperty
  a_shrt: assert property (p_shrt) else $error("shorted outputs");
  property p_dexit;
    scheme_o == UCPM_SCH_DIVIDER |=> scheme_o != UCPM_SCH_SHORTED;
  endproperty
  a_dexit: assert property (p_dexit) else $error("skipped low-pull");
  property p_sexit;
    scheme_o == UCPM_SCH_SHORTED |=>
      scheme_o inside {UCPM_SCH_SHORTED, UCPM_SCH_DIVIDER};
  endproperty
  a_sexit: assert property (p_sexit) else $error("bad shorted exit");
  property p_dsw; data_switch_o |-> dok_now || st.dok != 2'h0; endproperty
  a_dsw: assert property (p_dsw) else $error("data sw closed");
  property p_don;
    dok_now && st.dok == 2'h3 && !chg_now && st.chg == 4'h0
      && !discharge_o && st.ds == 3'h0 |-> data_switch_o;
  endproperty
  a_don: assert property (p_don) else $error("data switch open");
  property p_doff; discharge_o && st.ds[1:0] == 2'h3 |-> !data_switch_o;
  endproperty
  a_doff: assert property (p_doff) else $error("sw on in discharge");
  property p_dsc; $rose(discharge_o) |-> chg_now || st.chg != 4'h0;
  endproperty
  a_dsc: assert property (p_dsc) else $error("discharge with no cause");
endmodule

bind ucpm_port_logic ucpm_port_logic_checker ucpm_port_logic_checker_i (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
  .scheme_o, .short_lines_o, .drive_2v7_o, .pull_1v2_o, .data_switch_o,
  .discharge_o);

//--- ucpm_portable_model.sv
// Portable device model driving the attach and release comparators
`timescale 1ns/10ps

module ucpm_portable_model (
  input  logic       clk_i,
  input  logic [1:0] cmd_i,
  output logic       attach_o,
  output logic       release_o
);
  // ----------------
  // Comparator levels
  // ----------------
  // Bounce toggles every cycle, so it never stays still long enough
  always @(posedge clk_i) begin
    attach_o <= cmd_i == 2'h1 || (cmd_i == 2'h3 && !attach_o);
    release_o <= cmd_i == 2'h2;
  end
endmodule

//--- ucpm_port_logic_tb.sv
// Self-checking bench of the charging-port mode logic
`timescale 1ns/10ps

`define CHK(n, e, a) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("mismatch %s expected %h seen %h", n, e, a); \
  end \
end

module ucpm_port_logic_tb;
  import ucpm_pkg::*;
  // ----------------
  // Set-up
  // ----------------
  localparam int DISCH = 10;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i = 1'b0;
  logic [3:0]   adr_i = 4'h0;
  logic [3:0]   sel_i = 4'h0;
  logic [31:0]  dat_i = 32'h0;
  logic         overcurrent_i = 1'b0;
  logic         current_limit_i = 1'b0;
  logic [1:0]   cmd = 2'h0;
  logic [31:0]  dat_o, rd;
  logic         ack_o, attach_cmp_i, release_cmp_i;
  ucpm_scheme_t scheme_o;
  logic         short_lines_o, drive_2v7_o, pull_1v2_o, power_switch_o;
  logic         data_switch_o, discharge_o, fault_n_o;
  int           errors = 0;
  int           num_checks = 0;

  always #5 clk_i = ~clk_i;

  ucpm_port_logic #(.HOLD_CYCLES(20), .DISCH_CYCLES(DISCH))
    ucpm_port_logic_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .attach_cmp_i, .release_cmp_i, .overcurrent_i, .current_limit_i,
    .scheme_o, .short_lines_o, .drive_2v7_o, .pull_1v2_o, .power_switch_o,
    .data_switch_o, .discharge_o, .fault_n_o);
  ucpm_portable_model ucpm_portable_model_i (.clk_i, .cmd_i(cmd),
    .attach_o(attach_cmp_i), .release_o(release_cmp_i));

  // ----------------
  // Shared tasks
  // ----------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Bus cycle held until ack is sampled; the next call leaves an idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (k == 20) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic wait_sch(input ucpm_scheme_t s);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_i);
      if (scheme_o === s) break;
    end
    if (k == 300) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic quiet;
    repeat (8) begin
      tick(1);
      `CHK("dsc", 1'b0, discharge_o);
    end
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    wb(1'b0, 4'h4, 32'h0);
    `CHK("status", 32'h0, rd);
    wb(1'b1, 4'hc, 32'hf);
    wb(1'b0, 4'h0, 32'h0);
    `CHK("ctrl", 32'h0, rd);
    wb(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, rd);
    `CHK("scheme", UCPM_SCH_DIVIDER, scheme_o);
    $display("reset test done");
  endtask

  task automatic t_modes;
    logic [2:0] c;
    logic       f;
    overcurrent_i <= 1'b1;
    current_limit_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      f = c == 3'h0 || c == 3'h6 || c[2:1] == 2'h2;
      wb(1'b1, 4'h0, {28'h0, 1'b1, c});
      tick(DISCH + 8);
      `CHK("dsw", c[2:1] != 2'h0, data_switch_o);
      `CHK("pwr", c[2:1] != 2'h2, power_switch_o);
      `CHK("flt", f, fault_n_o);
    end
    wb(1'b1, 4'h0, 32'h7);
    tick(DISCH + 8);
    `CHK("dsw_off", 1'b0, data_switch_o);
    overcurrent_i <= 1'b0;
    current_limit_i <= 1'b0;
    $display("mode test done");
  endtask

  task automatic t_disch;
    int n;
    wb(1'b1, 4'h0, 32'h8);
    tick(DISCH + 8);
    wb(1'b1, 4'h0, 32'h9);
    quiet();
    wb(1'b1, 4'h0, 32'ha);
    tick(DISCH + 8);
    wb(1'b1, 4'h0, 32'hc);
    n = 0;
    for (int k = 0; k < 30 && discharge_o !== 1'b1; k++) tick(1);
    while (discharge_o === 1'b1 && n < 200) begin
      if (n > 0) `CHK("dsw_dsc", 1'b0, data_switch_o);
      n++;
      tick(1);
    end
    `CHK("dsc_len", DISCH, n);
    wb(1'b1, 4'h0, 32'he);
    tick(DISCH + 8);
    wb(1'b1, 4'h0, 32'hf);
    quiet();
    `CHK("dsw_cdp", 1'b1, data_switch_o);
    $display("discharge test done");
  endtask

  task automatic t_dcp;
    int n;
    wb(1'b1, 4'h0, 32'h8);
    tick(DISCH + 8);
    `CHK("div", 1'b1, drive_2v7_o);
    wb(1'b1, 4'h8, 32'h9);
    wb(1'b0, 4'h8, 32'h0);
    `CHK("hold", 32'h9, rd);
    cmd <= 2'h3;
    tick(60);
    `CHK("bounce", UCPM_SCH_DIVIDER, scheme_o);
    cmd <= 2'h1;
    wait_sch(UCPM_SCH_LOW_PULL);
    `CHK("pull", 1'b1, pull_1v2_o);
    `CHK("no_dsc", 1'b0, discharge_o);
    `CHK("pwr_on", 1'b1, power_switch_o);
    n = 0;
    while (scheme_o === UCPM_SCH_LOW_PULL && n < 100) begin
      n++;
      tick(1);
    end
    `CHK("hold_len", 9, n);
    `CHK("short", UCPM_SCH_SHORTED, scheme_o);
    cmd <= 2'h0;
    tick(60);
    wb(1'b0, 4'h4, 32'h0);
    `CHK("status", 32'ha, rd);
    cmd <= 2'h2;
    wait_sch(UCPM_SCH_DIVIDER);
    `CHK("short_off", 1'b0, short_lines_o);
    $display("auto-detect test done");
  endtask

  initial begin
    tick(12);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_disch();
    t_dcp();
    complete_run();
  end
endmodule
